//--- admcr_pkg.sv
// Package with register indices, field positions, reset values and codes of the mode-control bank.
// Operation
// RL1: Control word bit 15 selects read when 1, write when 0.
// RL2: Registers 22 and 23 are read-only; writes never change them.
// RL3: Bits 14..8 carry the register index, bits 7..0 the data byte.
// RL4: Each channel has its own 8-bit gain code, reset to all ones.
// RL5: Codes 15 to 255 give 0.5 dB times code minus 255.
// RL6: Codes 0 to 14 mean full mute of that channel.
// RL7: Channel codes are independent; one load-enable governs both channels.
// RL8: Load-enable 0 keeps applied gains; 1 applies newly written codes.
// RL9: Format field decodes six formats, reset 24-bit I2S, 110 and 111 reserved.
// RL10: In filter bypass mode the format field takes its alternative meaning.
// RL11: Emphasis frequency decodes off, 48, 44.1 and 32 kHz, reset off.
// RL12: Emphasis enable applies de-emphasis to both channels at selected frequency.
// RL13: In bitstream mode the emphasis field selects analog FIR performance.
// RL14: Soft mute bit mutes both channels together, reset unmuted.
// RL15: Soft mute is a 256-step ramp toward mute, step time from rate field; the code ramps 255 steps, from code 255 down to 0.
// RL16: Phase invert bit inverts output polarity of both channels.
// RL17: Rate field steps every 1, 2, 4 or 8 frame clocks, reset every one.
// RL18: Applied gain moves one 0.5 dB step per rate interval toward target.
// RL19: Reads return stored byte, reserved bits zero, read-only registers ignore writes.
package admcr_pkg;

	// ============================================================
	// Register indices
	localparam logic [6:0] ADMCR_IDX_LEFT = 7'h10;
	localparam logic [6:0] ADMCR_IDX_RIGHT = 7'h11;
	localparam logic [6:0] ADMCR_IDX_FMT = 7'h12;
	localparam logic [6:0] ADMCR_IDX_FILT = 7'h13;
	localparam logic [6:0] ADMCR_IDX_SYS = 7'h14;
	localparam logic [6:0] ADMCR_IDX_ZEN = 7'h15;
	localparam logic [6:0] ADMCR_IDX_ZST = 7'h16;
	localparam logic [6:0] ADMCR_IDX_DEVNUM = 7'h17;

	// ============================================================
	// Control word layout
	localparam int ADMCR_RW_BIT = 15;
	localparam int ADMCR_IDX_MSB = 14;
	localparam int ADMCR_IDX_LSB = 8;

	// ============================================================
	// Reset values
	localparam logic [7:0] ADMCR_RST_GAIN = 8'hFF;
	localparam logic [7:0] ADMCR_RST_FMT = 8'h50;
	localparam logic [7:0] ADMCR_RST_FILT = 8'h00;
	localparam logic [7:0] ADMCR_RST_SYS = 8'h00;
	localparam logic [7:0] ADMCR_RST_ZEN = 8'h01;

	// ============================================================
	// Writable masks; reserved bits read as zero
	localparam logic [7:0] ADMCR_MASK_FILT = 8'hF7;
	localparam logic [7:0] ADMCR_MASK_SYS = 8'h3F;
	localparam logic [7:0] ADMCR_MASK_ZEN = 8'h07;

	// ============================================================
	// Field positions
	localparam int ADMCR_BIT_LOAD = 7;
	localparam int ADMCR_FMT_LSB = 4;
	localparam int ADMCR_EMF_LSB = 2;
	localparam int ADMCR_BIT_EME = 1;
	localparam int ADMCR_BIT_MUTE = 0;
	localparam int ADMCR_BIT_INV = 7;
	localparam int ADMCR_RATE_LSB = 5;
	localparam int ADMCR_BIT_ODIS = 4;
	localparam int ADMCR_BIT_BSS = 2;
	localparam int ADMCR_BIT_ROLL = 1;
	localparam int ADMCR_BIT_EZM = 0;
	localparam int ADMCR_BIT_SOFT_SYSTEM_RESET = 6;
	localparam int ADMCR_BIT_DSD = 5;
	localparam int ADMCR_BIT_BYP = 4;

	// ============================================================
	// Gain codes
	localparam logic [7:0] ADMCR_MUTE_MAX = 8'h0E;
	localparam logic [7:0] ADMCR_GAIN_MIN = 8'h00;

	typedef enum logic [2:0] {
		ADMCR_IDLE = 3'b001,
		ADMCR_SHIFT = 3'b010,
		ADMCR_DONE = 3'b100
	} admcr_state_t;

endpackage

//--- admcr_regs.sv
// Mode-control register bank of a stereo audio converter with gain ramping.
`timescale 1ns/1ps
module admcr_regs #(
	parameter logic [4:0] DEVICE_NUMBER = 5'h05 // Value is arbitrary.
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic frame_clock,
	input wire logic word_valid,
	input wire logic [15:0] word_in,
	input wire logic left_zero_flag,
	input wire logic right_zero_flag,
	output logic [7:0] read_data,
	output logic read_valid,
	output logic [7:0] left_gain_code,
	output logic [7:0] right_gain_code,
	output logic left_mute,
	output logic right_mute,
	output logic [2:0] audio_word_format,
	output logic format_alt_meaning,
	output logic [1:0] emphasis_freq_select,
	output logic emphasis_enable,
	output logic [1:0] fir_perf_select,
	output logic phase_invert,
	output logic output_disable,
	output logic rolloff_select,
	output logic endless_zero_mute,
	output logic bypass_stereo_select,
	output logic [5:0] system_mode,
	output logic [2:0] zero_enable,
	output logic soft_system_reset
);
	import admcr_pkg::*;

	logic [7:0] left_attenuation;
	logic [7:0] right_attenuation;
	logic [7:0] format_emphasis_mute_control;
	logic [7:0] output_filter_control;
	logic [7:0] system_mode_control;
	logic [7:0] zero_flag_enable;
	logic [7:0] zero_flag_status;
	logic [7:0] left_target;
	logic [7:0] right_target;
	logic [2:0] frame_sync;
	logic [2:0] frame_div;
	logic frame_edge;
	logic rate_tick;
	logic [2:0] rate_mask;
	logic wr;
	logic rd;
	logic [6:0] idx;
	logic [7:0] wdata;
	logic [1:0] zero_meta;
	logic [1:0] zero_sync;

	// One ramp step of 0.5 dB toward the wanted code.
	function automatic logic [7:0] admcr_step(input logic [7:0] cur, input logic [7:0] want);
		logic [7:0] r;
		r = cur;
		if (cur < want) begin
			r = cur + 8'h01;
		end else if (cur > want) begin
			r = cur - 8'h01;
		end
		return r;
	endfunction

	// ============================================================
	// Control word decode
	assign wr = word_valid && !word_in[ADMCR_RW_BIT]; // [RL1]
	assign rd = word_valid && word_in[ADMCR_RW_BIT]; // [RL1]
	assign idx = word_in[ADMCR_IDX_MSB:ADMCR_IDX_LSB]; // [RL3]
	assign wdata = word_in[7:0]; // [RL3]

	// Register writes; the read-only indices have no write path at all.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_attenuation <= ADMCR_RST_GAIN; // [RL4]
			right_attenuation <= ADMCR_RST_GAIN; // [RL4]
			format_emphasis_mute_control <= ADMCR_RST_FMT; // [RL9]
			output_filter_control <= ADMCR_RST_FILT;
			system_mode_control <= ADMCR_RST_SYS;
			zero_flag_enable <= ADMCR_RST_ZEN;
		end else begin
			// The reset-request bit is write-only, so it self-clears after one cycle.
			system_mode_control[ADMCR_BIT_SOFT_SYSTEM_RESET] <= 1'b0;
			if (wr) begin
				if (idx == ADMCR_IDX_LEFT) begin
					left_attenuation <= wdata; // [RL7]
				end else if (idx == ADMCR_IDX_RIGHT) begin
					right_attenuation <= wdata; // [RL7]
				end else if (idx == ADMCR_IDX_FMT) begin
					format_emphasis_mute_control <= wdata;
				end else if (idx == ADMCR_IDX_FILT) begin
					output_filter_control <= wdata & ADMCR_MASK_FILT; // [RL19]
				end else if (idx == ADMCR_IDX_SYS) begin
					// The reset-request bit must be writable even though it never reads back.
					system_mode_control <= wdata & (ADMCR_MASK_SYS | (8'h01 << ADMCR_BIT_SOFT_SYSTEM_RESET)); // [RL19]
				end else if (idx == ADMCR_IDX_ZEN) begin
					zero_flag_enable <= wdata & ADMCR_MASK_ZEN; // [RL19]
				end
			end
		end
	end

	// Zero flags come from the audio path, so they pass two flops first.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_meta <= 2'h0;
			zero_sync <= 2'h0;
		end else begin
			zero_meta <= {right_zero_flag, left_zero_flag};
			zero_sync <= zero_meta;
		end
	end
	assign zero_flag_status = {6'h00, zero_sync}; // [RL2]

	// Readback of the stored byte, one cycle after the request.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			read_data <= 8'h00;
			read_valid <= 1'b0;
		end else begin
			read_valid <= rd;
			if (rd) begin
				if (idx == ADMCR_IDX_LEFT) begin
					read_data <= left_attenuation; // [RL19]
				end else if (idx == ADMCR_IDX_RIGHT) begin
					read_data <= right_attenuation;
				end else if (idx == ADMCR_IDX_FMT) begin
					read_data <= format_emphasis_mute_control;
				end else if (idx == ADMCR_IDX_FILT) begin
					read_data <= output_filter_control;
				end else if (idx == ADMCR_IDX_SYS) begin
					// Write-only reset bit never reads back.
					read_data <= system_mode_control & ~(8'h01 << ADMCR_BIT_SOFT_SYSTEM_RESET);
				end else if (idx == ADMCR_IDX_ZEN) begin
					read_data <= zero_flag_enable;
				end else if (idx == ADMCR_IDX_ZST) begin
					read_data <= zero_flag_status; // [RL2]
				end else if (idx == ADMCR_IDX_DEVNUM) begin
					read_data <= {3'h0, DEVICE_NUMBER}; // [RL2]
				end else begin
					read_data <= 8'h00;
				end
			end
		end
	end

	// ============================================================
	// Gain targets: codes are latched only while load-enable is set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_target <= ADMCR_RST_GAIN;
			right_target <= ADMCR_RST_GAIN;
		end else if (format_emphasis_mute_control[ADMCR_BIT_LOAD]) begin
			left_target <= left_attenuation; // [RL8]
			right_target <= right_attenuation; // [RL8]
		end
	end

	// Frame clock is a pin: synchronise, then detect rising edges.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_sync <= 3'h0;
		end else begin
			frame_sync <= {frame_sync[1:0], frame_clock};
		end
	end
	assign frame_edge = frame_sync[1] && !frame_sync[2];

	// Rate divider: step every 1, 2, 4 or 8 frames.
	always_comb begin
		case (output_filter_control[ADMCR_RATE_LSB +: 2])
			2'b00: rate_mask = 3'h0;
			2'b01: rate_mask = 3'h1;
			2'b10: rate_mask = 3'h3;
			default: rate_mask = 3'h7;
		endcase
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			frame_div <= 3'h0;
		end else if (frame_edge) begin
			frame_div <= frame_div + 3'h1; // [RL17]
		end
	end
	assign rate_tick = frame_edge && ((frame_div & rate_mask) == 3'h0); // [RL17]

	// Applied gain ramps one code per tick; soft mute ramps toward zero, 255 steps from full scale.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_gain_code <= ADMCR_RST_GAIN;
			right_gain_code <= ADMCR_RST_GAIN;
		end else if (rate_tick) begin
			if (format_emphasis_mute_control[ADMCR_BIT_MUTE]) begin
				left_gain_code <= admcr_step(left_gain_code, ADMCR_GAIN_MIN); // [RL14] [RL15]
				right_gain_code <= admcr_step(right_gain_code, ADMCR_GAIN_MIN); // [RL15]
			end else begin
				left_gain_code <= admcr_step(left_gain_code, left_target); // [RL18]
				right_gain_code <= admcr_step(right_gain_code, right_target); // [RL18]
			end
		end
	end

	// Mute flags and decoded mode outputs, all registered.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			left_mute <= 1'b0;
			right_mute <= 1'b0;
			audio_word_format <= ADMCR_RST_FMT[ADMCR_FMT_LSB +: 3];
			format_alt_meaning <= 1'b0;
			emphasis_freq_select <= 2'h0;
			emphasis_enable <= 1'b0;
			fir_perf_select <= 2'h0;
			phase_invert <= 1'b0;
			output_disable <= 1'b0;
			rolloff_select <= 1'b0;
			endless_zero_mute <= 1'b0;
			bypass_stereo_select <= 1'b0;
			system_mode <= 6'h00;
			zero_enable <= ADMCR_RST_ZEN[2:0];
			soft_system_reset <= 1'b0;
		end else begin
			// Codes 0..14 are infinite attenuation; 15..255 map linearly in the converter.
			left_mute <= (left_gain_code <= ADMCR_MUTE_MAX); // [RL5] [RL6]
			right_mute <= (right_gain_code <= ADMCR_MUTE_MAX); // [RL6]
			audio_word_format <= format_emphasis_mute_control[ADMCR_FMT_LSB +: 3]; // [RL9]
			format_alt_meaning <= system_mode_control[ADMCR_BIT_BYP]; // [RL10]
			// In bitstream mode the field drives the FIR select instead of emphasis.
			if (system_mode_control[ADMCR_BIT_DSD]) begin
				emphasis_freq_select <= 2'h0;
				emphasis_enable <= 1'b0;
				fir_perf_select <= format_emphasis_mute_control[ADMCR_EMF_LSB +: 2]; // [RL13]
			end else begin
				emphasis_freq_select <= format_emphasis_mute_control[ADMCR_EMF_LSB +: 2]; // [RL11]
				emphasis_enable <= format_emphasis_mute_control[ADMCR_BIT_EME]; // [RL12]
				fir_perf_select <= 2'h0;
			end
			phase_invert <= output_filter_control[ADMCR_BIT_INV]; // [RL16]
			output_disable <= output_filter_control[ADMCR_BIT_ODIS];
			rolloff_select <= output_filter_control[ADMCR_BIT_ROLL];
			endless_zero_mute <= output_filter_control[ADMCR_BIT_EZM];
			bypass_stereo_select <= output_filter_control[ADMCR_BIT_BSS];
			system_mode <= system_mode_control[5:0];
			zero_enable <= zero_flag_enable[2:0];
			soft_system_reset <= system_mode_control[ADMCR_BIT_SOFT_SYSTEM_RESET];
		end
	end

endmodule

//--- admcr_host.sv
// Host controller model that sends control words to the mode-control bank.
`timescale 1ns/1ps
module admcr_host (
	input wire logic clk,
	output logic word_valid,
	output logic [15:0] word_in
);
	// Idle bus at time zero so the bank sees no request during reset.
	initial begin
		word_valid = 1'b0;
		word_in = 16'h0000;
	end

	// One word per call, held for one edge, then a quiet edge so a new call never reassigns the strobe.
	task automatic send(input logic rd, input logic [6:0] idx, input logic [7:0] data);
		word_in <= {rd, idx, data};
		word_valid <= 1'b1;
		@(posedge clk);
		word_valid <= 1'b0;
		word_in <= ~word_in;
		@(posedge clk);
	endtask
endmodule

//--- admcr_checker.sv
// Concurrent checks on the ports of the mode-control bank.
`timescale 1ns/1ps
module admcr_checker #(
	parameter logic [4:0] DEVICE_NUMBER = 5'h05
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic word_valid,
	input wire logic [15:0] word_in,
	input wire logic [7:0] read_data,
	input wire logic read_valid,
	input wire logic [7:0] left_gain_code,
	input wire logic [7:0] right_gain_code,
	input wire logic left_mute,
	input wire logic right_mute,
	input wire logic phase_invert,
	input wire logic soft_system_reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Read and write answers, reset gains, mute decoding and ramp steps.
	chk_read_answer: assert property (word_valid && word_in[15] |=> read_valid)
		else $error("read word not answered");
	chk_write_quiet: assert property (word_valid && !word_in[15] |=> !read_valid)
		else $error("write word gave a read answer");
	chk_gain_reset: assert property ($rose(rst_n) |-> left_gain_code == 8'hFF && right_gain_code == 8'hFF)
		else $error("gain not full scale after reset");
	chk_left_mute: assert property (left_mute == ($past(left_gain_code) <= 8'h0E))
		else $error("left mute flag wrong");
	chk_right_mute: assert property (right_mute == ($past(right_gain_code) <= 8'h0E))
		else $error("right mute flag wrong");
	chk_gain_step: assert property ($changed(left_gain_code) |->
		left_gain_code == $past(left_gain_code) + 8'h01 || left_gain_code == $past(left_gain_code) - 8'h01)
		else $error("gain jumped more than one step");
	chk_id_read: assert property (word_valid && word_in[15:8] == 8'h97 |=> read_data == {3'b000, DEVICE_NUMBER})
		else $error("device number readback wrong");
	chk_zero_reserved: assert property (word_valid && word_in[15:8] == 8'h96 |=> read_data[7:2] == 6'h00)
		else $error("reserved flag bits not zero");
	chk_invert_cause: assert property ($changed(phase_invert) |-> $past(word_valid, 2) && ($past(word_in, 2) >> 8) == 16'h0013)
		else $error("phase invert changed without a write");
	chk_reset_pulse: assert property (word_valid && word_in[15:8] == 8'h14 && word_in[6] |=> ##1 soft_system_reset ##1 !soft_system_reset)
		else $error("system reset request gave no single pulse");
	cov_read: cover property (read_valid);
	cov_mute: cover property (left_mute && right_mute);
	cov_step: cover property ($changed(right_gain_code));
endmodule

bind admcr_regs admcr_checker #(.DEVICE_NUMBER(DEVICE_NUMBER)) admcr_checker_inst (.clk, .rst_n, .word_valid,
	.word_in, .read_data, .read_valid, .left_gain_code, .right_gain_code, .left_mute, .right_mute, .phase_invert,
	.soft_system_reset);

//--- testbench.sv
// Self-checking testbench of the mode-control bank.
`timescale 1ns/1ps
module testbench;
	import admcr_pkg::*;
	localparam logic [4:0] DEV = 5'h0B; // Value is arbitrary.
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic frame_clock = 1'b0;
	logic [1:0] zflag = 2'b00;
	logic word_valid, read_valid, left_mute, right_mute, alt, emph_en, phase_invert;
	logic [15:0] word_in;
	logic [7:0] read_data, left_gain_code, right_gain_code, lt, rt;
	logic [2:0] fmt;
	logic [1:0] emph_f;
	logic [7:0] exp_q[$];
	int miscompares = 0;
	int tests_run = 0;
	int seed = 47325;

	always #20 clk = ~clk;

	admcr_host admcr_host_inst (.clk(clk), .word_valid(word_valid), .word_in(word_in));
	admcr_regs #(.DEVICE_NUMBER(DEV)) admcr_regs_inst (.clk(clk), .rst_n(rst_n), .frame_clock(frame_clock),
		.word_valid(word_valid), .word_in(word_in), .left_zero_flag(zflag[0]), .right_zero_flag(zflag[1]),
		.read_data(read_data), .read_valid(read_valid), .left_gain_code(left_gain_code),
		.right_gain_code(right_gain_code), .left_mute(left_mute), .right_mute(right_mute),
		.audio_word_format(fmt), .format_alt_meaning(alt), .emphasis_freq_select(emph_f),
		.emphasis_enable(emph_en), .fir_perf_select(), .phase_invert(phase_invert), .output_disable(),
		.rolloff_select(), .endless_zero_mute(), .bypass_stereo_select(), .system_mode(), .zero_enable(),
		.soft_system_reset());

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [6:0] idx, input logic [7:0] data);
		@(posedge clk);
		admcr_host_inst.send(1'b0, idx, data);
	endtask

	task automatic rd(input logic [6:0] idx, input logic [7:0] exp);
		exp_q.push_back(exp);
		@(posedge clk);
		admcr_host_inst.send(1'b1, idx, 8'h00);
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	// Frame clock only moves inside this task, so ramp steps are counted exactly.
	task automatic frames(input int n);
		@(posedge clk);
		repeat (n) begin
			frame_clock <= 1'b1;
			repeat (4) @(posedge clk);
			frame_clock <= 1'b0;
			repeat (4) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic give_verdict();
		if (miscompares == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Each read answer takes the oldest expected byte; an answer nobody asked for fails.
	always @(posedge clk) begin
		if (read_valid === 1'b1) begin
			check(read_data, (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX);
		end
	end

	// Watchdog sized well above the longest ramp sequence.
	initial begin
		#2000000;
		miscompares++;
		give_verdict();
	end

	initial begin
		logic [7:0] rst_vals [8];
		rst_vals = '{8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00, 8'h01, 8'h00, {3'b000, DEV}};
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 8; i++) rd(ADMCR_IDX_LEFT + 7'(i), rst_vals[i]);
		rd(7'h05, 8'h00);
		zflag <= 2'($random(seed));
		repeat (5) @(posedge clk);
		rd(ADMCR_IDX_ZST, {6'h00, zflag});
		for (int i = 3; i < 8; i++) wr(ADMCR_IDX_LEFT + 7'(i), 8'hFF);
		settle();
		check(8'(phase_invert), 8'h01);
		check(8'(alt), 8'h01);
		rd(ADMCR_IDX_FILT, 8'hF7);
		rd(ADMCR_IDX_SYS, 8'h3F);
		rd(ADMCR_IDX_ZEN, 8'h07);
		rd(ADMCR_IDX_ZST, {6'h00, zflag});
		rd(ADMCR_IDX_DEVNUM, {3'b000, DEV});
		wr(ADMCR_IDX_FILT, 8'h00);
		wr(ADMCR_IDX_SYS, 8'h00);
		for (int i = 0; i < 8; i++) begin
			wr(ADMCR_IDX_FMT, {1'b0, 3'(i), 2'(i), i[0], 1'b0});
			settle();
			check(8'(fmt), 8'(i));
			check(8'(emph_f), 8'(i % 4));
			check(8'(emph_en), 8'(i % 2));
		end
		lt = 8'h3C + 8'($unsigned($random(seed)) % 196);
		rt = 8'h0F + 8'($unsigned($random(seed)) % 241);
		wr(ADMCR_IDX_LEFT, lt);
		wr(ADMCR_IDX_RIGHT, rt);
		rd(ADMCR_IDX_LEFT, lt);
		frames(4);
		check(left_gain_code, 8'hFF);
		wr(ADMCR_IDX_FMT, 8'h80);
		frames(260);
		check(left_gain_code, lt);
		check(right_gain_code, rt);
		wr(ADMCR_IDX_LEFT, 8'h0F);
		for (int i = 0; i < 4; i++) begin
			wr(ADMCR_IDX_FILT, 8'(i << 5));
			frames(16);
			lt = lt - 8'(16 >> i);
			check(left_gain_code, lt);
		end
		wr(ADMCR_IDX_FILT, 8'h00);
		wr(ADMCR_IDX_FMT, 8'h81);
		frames(260);
		check(left_gain_code, 8'h00);
		check(right_gain_code, 8'h00);
		check(8'({left_mute, right_mute}), 8'h03);
		wr(ADMCR_IDX_FMT, 8'h80);
		frames(260);
		check(left_gain_code, 8'h0F);
		check(right_gain_code, rt);
		check(8'(left_mute), 8'h00);
		check(8'(exp_q.size()), 8'h00);
		give_verdict();
	end
endmodule
